// file: rtl/ebt_defines.vh
// Register map, field positions and reset values of the eight-bit event timer
`ifndef EBT_DEFINES_VH
`define EBT_DEFINES_VH
`define EBT_ADDR_W 3
`define EBT_ADDR_COUNTER 3'h0
`define EBT_ADDR_CONST_A 3'h1
`define EBT_ADDR_CONST_B 3'h2
`define EBT_ADDR_CTRL_ZERO 3'h3
`define EBT_ADDR_CTRL_STATUS 3'h4
`define EBT_ADDR_CTRL_ONE 3'h5
`define EBT_ADDR_INT_STATUS 3'h6
`define EBT_ADDR_INT_MASK 3'h7
`define EBT_COUNTER_RESET 8'h00
`define EBT_CONST_RESET 8'hFF
`define EBT_CTRL_RESET 8'h00
`define EBT_CTRL_STATUS_FIXED 8'h10
`define EBT_CTRL_ONE_FIXED 8'hE2
`define EBT_CTRL_ONE_MASK 8'h1D
`define EBT_CTRL_STATUS_MASK 8'h0F
`define EBT_INT_MASK_BITS 8'hE0
// control_zero fields
`define EBT_BIT_IE_B 7
`define EBT_BIT_IE_A 6
`define EBT_BIT_IE_OVF 5
`define EBT_CLR_HI 4
`define EBT_CLR_LO 3
`define EBT_CKS_HI 2
`define EBT_CKS_LO 0
// control_status fields
`define EBT_BIT_FLAG_B 7
`define EBT_BIT_FLAG_A 6
`define EBT_BIT_FLAG_OVF 5
`define EBT_OSB_HI 3
`define EBT_OSB_LO 2
`define EBT_OSA_HI 1
`define EBT_OSA_LO 0
// control_one fields
`define EBT_TEDGE_HI 4
`define EBT_TEDGE_LO 3
`define EBT_BIT_TRIGGER_ENABLE 2
`define EBT_BIT_ICKS 0
// Encodings
`define EBT_CLR_NONE 2'b00
`define EBT_CLR_MATCH_A 2'b01
`define EBT_CLR_MATCH_B 2'b10
`define EBT_CLR_EXT_PIN 2'b11
`define EBT_EDGE_RISE 2'b01
`define EBT_EDGE_FALL 2'b10
`define EBT_EDGE_BOTH 2'b11
`define EBT_OUT_LOW 2'b01
`define EBT_OUT_HIGH 2'b10
`define EBT_OUT_TOGGLE 2'b11
`define EBT_PRESCALE_W 7
`endif

// file: rtl/ebt_timer.v
// Eight-bit event timer with compare match, clear, trigger and waveform output
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "ebt_defines.vh"

// What this block does
// - Eight-bit up-counter on selected clock; CPU reads and writes it anytime.
// - Counter overflow sets the overflow flag.
// - Reset loads the counter with zero.
// - Two identical read/write constant registers, reset to all ones.
// - Constants compared with counter; equality sets flag, interrupt if enabled.
// - No compare for a constant during a CPU write to that constant.
// - Control bits 7, 6, 5 enable match B, match A, overflow interrupts.
// - Clear field: never, match A, match B, external reset pin rising edge.
// - Count stop halts counting after clear; match and pin clear halt only with trigger enable.
// - Codes 000 and 100 stop; 001 to 011 count prescaled falling edges.
// - Codes 101, 110, 111 count external clock rising, falling, both edges.
// - Waveform output driven independently by both compare matches.
// - Counting can start on selected trigger pin edge.
// - Three interrupt sources, each gated by its own enable.
// - Output select per match: none, low, high, toggle.
// - Flags clear only by reading one then writing zero.
// - Trigger edge field: disabled, rising, falling, both.
// - Trigger enable starts on trigger edge, halts on compare or pin clear.
module ebt_timer (
    input wire clock,
    input wire rst_b,
    input wire [`EBT_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    input wire external_clock_pin,
    input wire external_reset_pin,
    input wire trigger_pin,
    output reg waveform_out_pin,
    output wire irq
);

    reg [7:0] event_counter;
    reg [7:0] compare_constant_a;
    reg [7:0] compare_constant_b;
    reg [7:0] timer_control_zero;
    reg [2:0] status_flags;
    reg [3:0] out_select;
    reg [1:0] trigger_edge;
    reg trigger_enable;
    reg internal_clock_pair_select;
    reg [2:0] clear_armed;
    reg [2:0] int_status;
    reg [2:0] int_mask;
    reg [`EBT_PRESCALE_W-1:0] prescale;
    reg [`EBT_PRESCALE_W-1:0] prescale_prev;
    reg run;
    reg eq_a_prev;
    reg eq_b_prev;
    reg [2:0] pin_meta;
    reg [2:0] pin_sync;
    reg [2:0] pin_last;

    wire [2:0] pin_raw;
    wire [2:0] pin_rise;
    wire [2:0] pin_fall;

    // Edge hit for a two-bit rise/fall/both select
    function edge_hit;
        input [1:0] sel;
        input rise;
        input fall;
        begin
            edge_hit = (sel[0] & rise) | (sel[1] & fall);
        end
    endfunction

    // Output pin action for one compare match
    function out_action;
        input cur;
        input [1:0] sel;
        begin
            case (sel)
                `EBT_OUT_LOW: out_action = 1'b0;
                `EBT_OUT_HIGH: out_action = 1'b1;
                `EBT_OUT_TOGGLE: out_action = ~cur;
                default: out_action = cur;
            endcase
        end
    endfunction

    assign pin_raw = {trigger_pin, external_reset_pin, external_clock_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                    pin_last[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                    pin_last[gi] <= pin_sync[gi];
                end
            end
            assign pin_rise[gi] = pin_sync[gi] & ~pin_last[gi];
            assign pin_fall[gi] = ~pin_sync[gi] & pin_last[gi];
        end
    endgenerate

    wire [2:0] cks = timer_control_zero[`EBT_CKS_HI:`EBT_CKS_LO];
    wire [1:0] clr_sel = timer_control_zero[`EBT_CLR_HI:`EBT_CLR_LO];
    wire wr_counter = reg_write && (reg_addr == `EBT_ADDR_COUNTER);
    wire wr_const_a = reg_write && (reg_addr == `EBT_ADDR_CONST_A);
    wire wr_const_b = reg_write && (reg_addr == `EBT_ADDR_CONST_B);
    wire wr_status = reg_write && (reg_addr == `EBT_ADDR_CTRL_STATUS);
    wire rd_status = reg_read && (reg_addr == `EBT_ADDR_CTRL_STATUS);
    wire rd_int = reg_read && (reg_addr == `EBT_ADDR_INT_STATUS);

    // prescaled falling edge
    // Tap 1 divides by 4, tap 6 by 128
    reg int_tick;
    reg [2:0] div_idx;
    always @* begin
        // Stop codes park the tap so the index never leaves the prescaler
        div_idx = 3'd0;
        if (cks[1:0] != 2'b00) begin
            div_idx = {cks[1:0], internal_clock_pair_select} - 3'd1;
        end
        int_tick = prescale_prev[div_idx] & ~prescale[div_idx];
    end

    reg count_tick;
    always @* begin
        count_tick = 1'b0;
        if (cks[2]) begin
            // external clock edges
            // Code 100 selects no edge, so it counts nothing
            count_tick = edge_hit(cks[1:0], pin_rise[0], pin_fall[0]);
        end else if (cks[1:0] != 2'b00) begin
            count_tick = int_tick;
        end
    end

    wire eq_a = (event_counter == compare_constant_a) && !wr_const_a;
    wire eq_b = (event_counter == compare_constant_b) && !wr_const_b;
    // One match event per entry into equality, so toggles do not chatter
    wire match_a = eq_a && !eq_a_prev;
    wire match_b = eq_b && !eq_b_prev;

    wire clear_match = (clr_sel == `EBT_CLR_MATCH_A && match_a) ||
        (clr_sel == `EBT_CLR_MATCH_B && match_b);
    wire clear_pin = (clr_sel == `EBT_CLR_EXT_PIN) && pin_rise[1];
    wire counter_clear = clear_match || clear_pin;

    wire trigger_hit = edge_hit(trigger_edge, pin_rise[2], pin_fall[2]);
    wire counting = !trigger_enable || run;
    wire inc = count_tick && counting;
    wire overflow = inc && (event_counter == 8'hFF) && !counter_clear && !wr_counter;

    // Each event
    wire [2:0] flag_set = {match_b, match_a, overflow};
    wire [2:0] irq_enable = timer_control_zero[`EBT_BIT_IE_B:`EBT_BIT_IE_OVF];

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prescale <= {`EBT_PRESCALE_W{1'b0}};
            prescale_prev <= {`EBT_PRESCALE_W{1'b0}};
            eq_a_prev <= 1'b0;
            eq_b_prev <= 1'b0;
        end else begin
            prescale <= prescale + 1'b1;
            prescale_prev <= prescale;
            eq_a_prev <= eq_a;
            eq_b_prev <= eq_b;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            event_counter <= `EBT_COUNTER_RESET;
        end else if (wr_counter) begin
            event_counter <= reg_wdata;
        end else if (counter_clear) begin
            event_counter <= 8'h00;
        end else if (inc) begin
            event_counter <= event_counter + 8'h01;
        end
    end

    // halt after clear
    // With trigger enabled any clear halts, pin clear included
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run <= 1'b0;
        end else if (!trigger_enable) begin
            run <= 1'b0;
        end else if (counter_clear) begin
            run <= 1'b0;
        end else if (trigger_hit) begin
            run <= 1'b1;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            compare_constant_a <= `EBT_CONST_RESET;
            compare_constant_b <= `EBT_CONST_RESET;
            timer_control_zero <= `EBT_CTRL_RESET;
            out_select <= 4'h0;
            trigger_edge <= 2'b00;
            trigger_enable <= 1'b0;
            internal_clock_pair_select <= 1'b0;
            int_mask <= 3'b000;
        end else if (reg_write) begin
            case (reg_addr)
                `EBT_ADDR_CONST_A: compare_constant_a <= reg_wdata;
                `EBT_ADDR_CONST_B: compare_constant_b <= reg_wdata;
                `EBT_ADDR_CTRL_ZERO: timer_control_zero <= reg_wdata;
                `EBT_ADDR_CTRL_STATUS: out_select <= reg_wdata[`EBT_OSB_HI:`EBT_OSA_LO];
                `EBT_ADDR_CTRL_ONE: begin
                    trigger_edge <= reg_wdata[`EBT_TEDGE_HI:`EBT_TEDGE_LO];
                    trigger_enable <= reg_wdata[`EBT_BIT_TRIGGER_ENABLE];
                    internal_clock_pair_select <= reg_wdata[`EBT_BIT_ICKS];
                end
                `EBT_ADDR_INT_MASK: int_mask <= reg_wdata[`EBT_BIT_FLAG_B:`EBT_BIT_FLAG_OVF];
                default: ;
            endcase
        end
    end

    // read-then-write clear
    // A new event in the clearing cycle wins over the clear
    // overflow sets its flag
    wire [2:0] clear_req = (wr_status ? ~reg_wdata[7:5] : 3'b000) & clear_armed;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            status_flags <= 3'b000;
            clear_armed <= 3'b000;
        end else begin
            status_flags <= flag_set | (status_flags & ~clear_req);
            if (rd_status) begin
                clear_armed <= status_flags;
            end else if (wr_status) begin
                clear_armed <= 3'b000;
            end
        end
    end

    // gated interrupt sources
    // Read clears, a set in the same cycle wins
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            int_status <= 3'b000;
        end else begin
            int_status <= (flag_set & irq_enable) | (rd_int ? 3'b000 : int_status);
        end
    end
    assign irq = |(int_status & int_mask);

    // independent match actions
    // When both hit at once, B is applied after A
    // per-match output action
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            waveform_out_pin <= 1'b0;
        end else begin
            waveform_out_pin <= out_action(
                match_a ? out_action(waveform_out_pin, out_select[1:0]) : waveform_out_pin,
                match_b ? out_select[3:2] : 2'b00);
        end
    end

    // Read data one cycle after the strobe; status bit 4 and control one bits 7:5 and 1 read one, other unused bits zero
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `EBT_ADDR_COUNTER: reg_rdata <= event_counter;
                `EBT_ADDR_CONST_A: reg_rdata <= compare_constant_a;
                `EBT_ADDR_CONST_B: reg_rdata <= compare_constant_b;
                `EBT_ADDR_CTRL_ZERO: reg_rdata <= timer_control_zero;
                `EBT_ADDR_CTRL_STATUS: reg_rdata <= {status_flags, 1'b1, out_select};
                `EBT_ADDR_CTRL_ONE: reg_rdata <= {3'b111, trigger_edge, trigger_enable,
                    1'b1, internal_clock_pair_select};
                `EBT_ADDR_INT_STATUS: reg_rdata <= {int_status, 5'h00};
                `EBT_ADDR_INT_MASK: reg_rdata <= {int_mask, 5'h00};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // ebt_timer

// file: testbench/ebt_timer_asserts.sv
// Port-level checker of the eight-bit event timer
`timescale 1ns/1ns
`include "ebt_defines.vh"
module ebt_timer_chk (
    input wire clock,
    input wire rst_b,
    input wire [`EBT_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_rdata,
    input wire waveform_out_pin,
    input wire irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_rd_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_const_back; (reg_write && reg_addr == `EBT_ADDR_CONST_A) ##1 (reg_read &&
        reg_addr == `EBT_ADDR_CONST_A) |=> reg_rdata == $past(reg_wdata, 2); endproperty
    a_const_back: assert property (p_const_back) else $error("constant readback");
    property p_ctl0_back; (reg_write && reg_addr == `EBT_ADDR_CTRL_ZERO) ##1 (reg_read &&
        reg_addr == `EBT_ADDR_CTRL_ZERO) |=> reg_rdata == $past(reg_wdata, 2); endproperty
    a_ctl0_back: assert property (p_ctl0_back) else $error("control readback");
    property p_ctl1_back; (reg_write && reg_addr == `EBT_ADDR_CTRL_ONE) ##1 (reg_read &&
        reg_addr == `EBT_ADDR_CTRL_ONE) |=> reg_rdata == (($past(reg_wdata, 2) & 8'h1D) | 8'hE2);
    endproperty
    a_ctl1_back: assert property (p_ctl1_back) else $error("control one readback");
    property p_mask_back; (reg_write && reg_addr == `EBT_ADDR_INT_MASK) ##1 (reg_read &&
        reg_addr == `EBT_ADDR_INT_MASK) |=> reg_rdata == ($past(reg_wdata, 2) & 8'hE0); endproperty
    a_mask_back: assert property (p_mask_back) else $error("mask readback");
    property p_stat_fix; reg_read && reg_addr == `EBT_ADDR_CTRL_STATUS |=> reg_rdata[4]; endproperty
    a_stat_fix: assert property (p_stat_fix) else $error("status fixed bit");
    property p_out_rst; $rose(rst_b) |-> !waveform_out_pin ##1 !waveform_out_pin; endproperty
    a_out_rst: assert property (p_out_rst) else $error("output not low after reset");
    property p_irq_rst; $rose(rst_b) |-> !irq [*3]; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("interrupt after reset");
    property p_rd_pulse; reg_read ##1 !reg_read |=> reg_rdata == 8'h00; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read data held too long");
    c_irq: cover property ($rose(irq));
    c_wave: cover property ($rose(waveform_out_pin));
    c_wr_rd: cover property (reg_write ##1 reg_read);
endmodule // ebt_timer_chk
bind ebt_timer ebt_timer_chk u_ebt_timer_chk (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .waveform_out_pin(waveform_out_pin), .irq(irq));

// file: testbench/ebt_pin_source.sv
// Stand-in for the external clock, clear and trigger sources
`timescale 1ns/1ns
module ebt_pin_source #(
    parameter HOLD = 6
) (
    input wire clock,
    output reg ext_clk,
    output reg ext_rst,
    output reg trig
);
    initial begin
        ext_clk = 1'b0;
        ext_rst = 1'b0;
        trig = 1'b0;
    end
    // Levels held HOLD clocks so the synchroniser cannot miss them
    task clk_edges(input integer n);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1) begin
                ext_clk <= ~ext_clk;
                repeat (HOLD) @(posedge clock);
            end
        end
    endtask
    task trig_pulse;
        begin
            trig <= 1'b1;
            repeat (HOLD) @(posedge clock);
            trig <= 1'b0;
            repeat (HOLD) @(posedge clock);
        end
    endtask
    task trig_level(input v);
        begin
            trig <= v;
            repeat (HOLD) @(posedge clock);
        end
    endtask
    task rst_pulse;
        begin
            ext_rst <= 1'b1;
            repeat (HOLD) @(posedge clock);
            ext_rst <= 1'b0;
            repeat (HOLD) @(posedge clock);
        end
    endtask
endmodule // ebt_pin_source

// file: testbench/tb_top.sv
// Self-checking bench of the eight-bit event timer
`timescale 1ns/1ns
`include "ebt_defines.vh"
module tb_top;
    reg clock = 1'b0;
    reg rst_b = 1'b0;
    reg [2:0] reg_addr = 3'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    wire [7:0] reg_rdata;
    wire ext_clk, ext_rst, trig, waveform_out_pin, irq;
    integer n_mismatch = 0;
    integer samples_checked = 0;
    integer i;
    reg [7:0] rd_val;
    // Row: write flag and address, then data or expected read value
    reg [11:0] rows [0:20] = '{12'h000, 12'h1FF, 12'h2FF, 12'h300, 12'h410, 12'h5E2, 12'h600,
        12'h700, 12'h95A, 12'h15A, 12'hDFF, 12'h5FF, 12'hD00, 12'hC0F, 12'h41F, 12'hC00,
        12'hFFF, 12'h7E0, 12'hBA5, 12'h3A5, 12'hB00};
    always #4 clock = ~clock;
    ebt_timer u_ebt_timer (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .external_clock_pin(ext_clk), .external_reset_pin(ext_rst),
        .trigger_pin(trig), .waveform_out_pin(waveform_out_pin), .irq(irq));
    ebt_pin_source u_ebt_pin_source (.clock(clock), .ext_clk(ext_clk), .ext_rst(ext_rst),
        .trig(trig));
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input [8*6-1:0] name, input [7:0] seen, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // Strobe left high so a read may follow with no gap
    task wr(input [2:0] a, input [7:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_read <= 1'b0;
            reg_write <= 1'b1;
            @(posedge clock);
        end
    endtask
    task rd(input [2:0] a);
        begin
            reg_addr <= a;
            reg_write <= 1'b0;
            reg_read <= 1'b1;
            @(posedge clock);
            reg_read <= 1'b0;
            @(posedge clock);
            rd_val = reg_rdata;
        end
    endtask
    task idle(input integer n);
        begin
            reg_write <= 1'b0;
            reg_read <= 1'b0;
            repeat (n) @(posedge clock);
        end
    endtask
    initial begin
        #160000;
        n_mismatch = n_mismatch + 1;
        end_sim;
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        for (i = 0; i < 21; i = i + 1) begin
            if (rows[i][11])
                wr(rows[i][10:8], rows[i][7:0]);
            else begin
                rd(rows[i][10:8]);
                chk("reg", rd_val, rows[i][7:0]);
            end
        end
        // Match A toggles output, clears counter, raises interrupt
        wr(`EBT_ADDR_CONST_A, 8'h03);
        wr(`EBT_ADDR_CTRL_STATUS, 8'h03);
        wr(`EBT_ADDR_INT_MASK, 8'hE0);
        wr(`EBT_ADDR_CTRL_ZERO, 8'h49);
        idle(1);
        for (i = 0; i < 100 && irq !== 1'b1; i = i + 1)
            @(posedge clock);
        chk("irq", {7'h0, irq}, 8'h01);
        wr(`EBT_ADDR_CTRL_ZERO, 8'h48);
        idle(2);
        chk("wave", {7'h0, waveform_out_pin}, 8'h01);
        rd(`EBT_ADDR_COUNTER);
        chk("count", {7'h0, rd_val < 8'h04}, 8'h01);
        // Write of zero without a prior read must not clear the flag
        wr(`EBT_ADDR_CTRL_STATUS, 8'h03);
        rd(`EBT_ADDR_CTRL_STATUS);
        chk("stat", rd_val, 8'h53);
        wr(`EBT_ADDR_CTRL_STATUS, 8'h03);
        rd(`EBT_ADDR_CTRL_STATUS);
        chk("stat", rd_val, 8'h13);
        rd(`EBT_ADDR_INT_STATUS);
        chk("int", rd_val, 8'h40);
        chk("irq", {7'h0, irq}, 8'h00);
        // Overflow on both external clock edges, interrupt masked first
        wr(`EBT_ADDR_INT_MASK, 8'h00);
        wr(`EBT_ADDR_COUNTER, 8'hFE);
        wr(`EBT_ADDR_CTRL_ZERO, 8'h27);
        idle(1);
        u_ebt_pin_source.clk_edges(2);
        rd(`EBT_ADDR_COUNTER);
        chk("count", rd_val, 8'h00);
        rd(`EBT_ADDR_CTRL_STATUS);
        chk("stat", rd_val, 8'hB3);
        chk("irq", {7'h0, irq}, 8'h00);
        wr(`EBT_ADDR_INT_MASK, 8'hE0);
        idle(1);
        chk("irq", {7'h0, irq}, 8'h01);
        rd(`EBT_ADDR_INT_STATUS);
        chk("int", rd_val, 8'h20);
        // Trigger start, then pin clear halts the counter
        wr(`EBT_ADDR_CTRL_ZERO, 8'h00);
        wr(`EBT_ADDR_COUNTER, 8'h10);
        wr(`EBT_ADDR_CTRL_ONE, 8'h0C);
        wr(`EBT_ADDR_CTRL_ZERO, 8'h19);
        idle(20);
        rd(`EBT_ADDR_COUNTER);
        chk("count", rd_val, 8'h10);
        u_ebt_pin_source.trig_pulse;
        rd(`EBT_ADDR_COUNTER);
        chk("count", {7'h0, rd_val > 8'h10}, 8'h01);
        u_ebt_pin_source.rst_pulse;
        rd(`EBT_ADDR_COUNTER);
        chk("count", rd_val, 8'h00);
        // Match A drives low, match B drives high and clears
        wr(`EBT_ADDR_CTRL_ZERO, 8'h00);
        wr(`EBT_ADDR_CTRL_ONE, 8'h00);
        wr(`EBT_ADDR_CONST_A, 8'h01);
        wr(`EBT_ADDR_CONST_B, 8'h03);
        wr(`EBT_ADDR_CTRL_STATUS, 8'h09);
        wr(`EBT_ADDR_CTRL_ZERO, 8'h15);
        idle(1);
        u_ebt_pin_source.clk_edges(2);
        chk("wave", {7'h0, waveform_out_pin}, 8'h00);
        u_ebt_pin_source.clk_edges(4);
        chk("wave", {7'h0, waveform_out_pin}, 8'h01);
        rd(`EBT_ADDR_COUNTER);
        chk("count", rd_val, 8'h00);
        // Slowest prescaled clock, then code 100 ignores the pin
        wr(`EBT_ADDR_CTRL_ONE, 8'h01);
        wr(`EBT_ADDR_CTRL_ZERO, 8'h03);
        idle(300);
        rd(`EBT_ADDR_COUNTER);
        chk("count", {7'h0, rd_val == 8'h02 || rd_val == 8'h03}, 8'h01);
        wr(`EBT_ADDR_COUNTER, 8'h20);
        wr(`EBT_ADDR_CTRL_ZERO, 8'h04);
        idle(1);
        u_ebt_pin_source.clk_edges(2);
        rd(`EBT_ADDR_COUNTER);
        chk("count", rd_val, 8'h20);
        // Falling trigger edge only: the rise must not start the count
        wr(`EBT_ADDR_COUNTER, 8'h40);
        wr(`EBT_ADDR_CONST_B, 8'h41);
        wr(`EBT_ADDR_CTRL_ONE, 8'h14);
        wr(`EBT_ADDR_CTRL_ZERO, 8'h81);
        idle(1);
        u_ebt_pin_source.trig_level(1'b1);
        idle(8);
        rd(`EBT_ADDR_COUNTER);
        chk("count", rd_val, 8'h40);
        u_ebt_pin_source.trig_level(1'b0);
        idle(8);
        rd(`EBT_ADDR_COUNTER);
        chk("count", {7'h0, rd_val > 8'h40}, 8'h01);
        chk("irq", {7'h0, irq}, 8'h01);
        chk("wave", {7'h0, waveform_out_pin}, 8'h01);
        // Reset in mid-run returns output, interrupt and registers to idle
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        chk("wave", {7'h0, waveform_out_pin}, 8'h00);
        chk("irq", {7'h0, irq}, 8'h00);
        rd(`EBT_ADDR_COUNTER);
        chk("count", rd_val, 8'h00);
        rd(`EBT_ADDR_CONST_B);
        chk("constb", rd_val, 8'hFF);
        end_sim;
    end
endmodule // tb_top
